/* rtl/memory_mode_strap_pin_mux.v */
// memory-mode strap capture and external pin multiplexer
`timescale 1ns/10ps
`include "strap_mux_defs.vh"

// Function
// [R1] strap low selects full, high selects host
// [R2] mode frozen after reset until next reset
// [R3] full mode drives fourteen address outputs
// [R4] full mode 24-bit data, top byte carries address
// [R5] host mode 16-bit port with strobes, acknowledge
// [R6] host mode: one address pin, data on top
// [R7] outside logic decodes peripherals from selects
// [R8] mode pins read in reset, flags afterwards
// [R9] second serial port pins: irqs, flag in/out
// [R10] outside strap driver floats after reset
// [R11] registered mode value steers address, data and host port pin functions
module memory_mode_strap_pin_mux (
  input wire clk_i,
  input wire rst_b_i,
  // mode pins doubling as programmable flags
  input wire prog_flag_zero_i,
  input wire prog_flag_one_i,
  input wire prog_flag_two_i,
  output wire [`FLAG_W-1:0] prog_flag_out_o,
  output wire [`FLAG_W-1:0] prog_flag_oe_o,
  input wire [`FLAG_W-1:0] flag_drive_i,
  input wire [`FLAG_W-1:0] flag_dir_out_i,
  output wire [`FLAG_W-1:0] flag_level_o,
  output reg host_mode_o,
  output reg [`FLAG_W-1:0] strap_value_o,
  // core side of the external memory interface
  input wire [`ADDR_W-1:0] core_addr_i,
  input wire [`DATA_W-1:0] core_wdata_i,
  input wire core_data_oe_i,
  input wire core_byte_phase_i,
  input wire [`BYTE_ADDR_W-1:0] core_byte_addr_i,
  output reg [`DATA_W-1:0] core_rdata_o,
  input wire core_cms_b_i,
  input wire core_pms_b_i,
  input wire core_dms_b_i,
  input wire core_io_space_select_b_i,
  input wire core_bms_b_i,
  // external memory pins
  output reg [`ADDR_W-1:0] ext_addr_out_o,
  input wire [`DATA_W-1:0] ext_data_bus_in_i,
  output wire [`DATA_W-1:0] ext_data_bus_out_o,
  output wire [`DATA_W-1:0] ext_data_bus_oe_o,
  output reg combined_mem_select_b_o,
  output reg program_mem_select_b_o,
  output reg data_mem_select_b_o,
  output reg io_space_select_b_o,
  output reg byte_mem_select_b_o,
  // host access port pins
  input wire [`HOST_W-1:0] host_addr_data_bus_in_i,
  output wire [`HOST_W-1:0] host_addr_data_bus_out_o,
  output wire [`HOST_W-1:0] host_addr_data_bus_oe_o,
  input wire host_write_strobe_b_i,
  input wire host_read_strobe_b_i,
  input wire host_addr_latch_i,
  input wire host_select_b_i,
  output reg host_acknowledge_b_o,
  // core side of the host access port
  input wire [`HOST_W-1:0] hport_rdata_i,
  input wire hport_drive_i,
  input wire hport_ack_i,
  output reg [`HOST_W-1:0] hport_bus_o,
  output reg hport_write_o,
  output reg hport_read_o,
  output reg hport_latch_o,
  output reg hport_select_o,
  // second serial port pins
  input wire [`SER_W-1:0] serial_pin_in_i,
  output wire [`SER_W-1:0] serial_pin_out_o,
  output wire [`SER_W-1:0] serial_pin_oe_o,
  input wire serial_alt_en_i,
  input wire [`SER_W-1:0] serial_drive_i,
  input wire [`SER_W-1:0] serial_oe_i,
  output reg [`SER_W-1:0] serial_level_o,
  input wire [`IRQ_W-1:0] irq_edge_mode_i,
  input wire flag_output_i,
  output reg flag_input_o,
  output reg [`IRQ_W-1:0] serial_alt_interrupts_o
);

  // reset synchroniser: first stage is read only by the second
  reg rst_meta_reg;
  reg rst_n_reg;
  // strap capture, loaded every cycle while reset is held
  reg [`FLAG_W-1:0] strap_reg;
  // previous interrupt pin levels for falling edge detection
  reg [`IRQ_W-1:0] irq_prev_reg;
  wire mode_host;
  wire [`DATA_W-1:0] data_sample;
  wire [`HOST_W-1:0] host_sample;
  wire [`SER_W-1:0] ser_sample;
  reg [`DATA_W-1:0] data_drive_next;
  reg [`DATA_W-1:0] data_oe_next;
  reg [`SER_W-1:0] ser_drive_next;
  reg [`SER_W-1:0] ser_oe_next;
  reg [`IRQ_W-1:0] irq_next;
  wire [`IRQ_W-1:0] irq_level;

  // release reset through two flops, assert at once
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // strap is a clocked capture, not a reset value; last sample before release sticks
  always @(posedge clk_i) begin
    if (!rst_n_reg) begin // [R2]
      strap_reg <= {prog_flag_two_i, prog_flag_one_i, prog_flag_zero_i}; // [R8] [R1]
    end
  end
  // strap_reg holds after release; only a new reset reloads it  [R2]

  assign mode_host = strap_reg[`STRAP_C_BIT]; // [R11]

  // mode status, published once reset is gone
  always @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      host_mode_o <= `MODE_FULL;
      strap_value_o <= {`FLAG_W{1'b0}};
    end else begin
      host_mode_o <= mode_host; // [R1]
      strap_value_o <= strap_reg;
    end
  end

  // flag pins: enables stay low in reset so the outside strap driver is not fought
  pin_cell #(.W(`FLAG_W)) flag_pins (
    .clk_i(clk_i),
    .rst_n_i(rst_n_reg),
    .drive_i(flag_drive_i),
    .oe_i(flag_dir_out_i),
    .pin_in_i({prog_flag_two_i, prog_flag_one_i, prog_flag_zero_i}),
    .pin_out_o(prog_flag_out_o),
    .pin_oe_o(prog_flag_oe_o),
    .sample_o(flag_level_o)
  ); // [R8] [R10]

  // data bus drive and enable by mode
  always @* begin
    data_drive_next = {`DATA_W{1'b0}};
    data_oe_next = {`DATA_W{1'b0}};
    if (mode_host == `MODE_HOST) begin
      // sixteen data bits ride the upper lines, low byte floats
      data_drive_next[`DATA_W-1:`DATA_HIGH_LSB] = core_wdata_i[`HOST_DATA_MSB:0]; // [R6]
      data_oe_next[`DATA_W-1:`DATA_HIGH_LSB] = {(`DATA_W-`DATA_HIGH_LSB){core_data_oe_i}};
    end else begin
      data_drive_next = core_wdata_i; // [R4]
      data_oe_next = {`DATA_W{core_data_oe_i}};
      // byte access: top byte carries high byte-memory address, always driven
      if (core_byte_phase_i) begin
        data_drive_next[`DATA_W-1:`DATA_W-`BYTE_ADDR_W] = core_byte_addr_i; // [R4]
        data_oe_next[`DATA_W-1:`DATA_W-`BYTE_ADDR_W] = {`BYTE_ADDR_W{1'b1}};
      end
    end
  end

  pin_cell #(.W(`DATA_W)) data_pins (
    .clk_i(clk_i),
    .rst_n_i(rst_n_reg),
    .drive_i(data_drive_next),
    .oe_i(data_oe_next),
    .pin_in_i(ext_data_bus_in_i),
    .pin_out_o(ext_data_bus_out_o),
    .pin_oe_o(ext_data_bus_oe_o),
    .sample_o(data_sample)
  );

  // address, selects and read data; selects pass in both modes for outside decode
  always @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ext_addr_out_o <= `ZERO_ADDR;
      core_rdata_o <= {`DATA_W{1'b0}};
      combined_mem_select_b_o <= `SEL_IDLE;
      program_mem_select_b_o <= `SEL_IDLE;
      data_mem_select_b_o <= `SEL_IDLE;
      io_space_select_b_o <= `SEL_IDLE;
      byte_mem_select_b_o <= `SEL_IDLE;
    end else begin
      if (mode_host == `MODE_HOST) begin
        // only the least significant address pin survives
        ext_addr_out_o <= {{(`ADDR_W-1){1'b0}}, core_addr_i[0]}; // [R6]
        core_rdata_o <= {`ZERO_BYTE, data_sample[`DATA_W-1:`DATA_HIGH_LSB]}; // [R6]
      end else begin
        ext_addr_out_o <= core_addr_i; // [R3]
        core_rdata_o <= data_sample; // [R4]
      end
      // outside glue decodes peripherals from these and the low address pin  [R7]
      combined_mem_select_b_o <= core_cms_b_i;
      program_mem_select_b_o <= core_pms_b_i;
      data_mem_select_b_o <= core_dms_b_i;
      io_space_select_b_o <= core_io_space_select_b_i;
      byte_mem_select_b_o <= core_bms_b_i;
    end
  end

  // host port bus: driven only in host mode when the core answers a read
  pin_cell #(.W(`HOST_W)) host_pins (
    .clk_i(clk_i),
    .rst_n_i(rst_n_reg),
    .drive_i(hport_rdata_i),
    .oe_i({`HOST_W{hport_drive_i & mode_host}}),
    .pin_in_i(host_addr_data_bus_in_i),
    .pin_out_o(host_addr_data_bus_out_o),
    .pin_oe_o(host_addr_data_bus_oe_o),
    .sample_o(host_sample)
  ); // [R5]

  // host strobes gated by mode, so full mode ignores a floating host port
  always @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      hport_bus_o <= {`HOST_W{1'b0}};
      hport_write_o <= 1'b0;
      hport_read_o <= 1'b0;
      hport_latch_o <= 1'b0;
      hport_select_o <= 1'b0;
      host_acknowledge_b_o <= `SEL_IDLE;
    end else begin
      hport_bus_o <= mode_host ? host_sample : {`HOST_W{1'b0}}; // [R5]
      hport_write_o <= mode_host & ~host_write_strobe_b_i;
      hport_read_o <= mode_host & ~host_read_strobe_b_i;
      hport_latch_o <= mode_host & host_addr_latch_i;
      hport_select_o <= mode_host & ~host_select_b_i;
      host_acknowledge_b_o <= ~(mode_host & hport_ack_i); // [R5]
    end
  end

  // serial pins: alternate set turns three pins into inputs and one into a flag out
  always @* begin
    ser_drive_next = serial_drive_i;
    ser_oe_next = serial_oe_i;
    if (serial_alt_en_i) begin
      ser_oe_next[`SER_IRQ0_PIN] = 1'b0; // [R9]
      ser_oe_next[`SER_IRQ1_PIN] = 1'b0;
      ser_oe_next[`SER_FI_PIN] = 1'b0;
      ser_drive_next[`SER_FO_PIN] = flag_output_i; // [R9]
      ser_oe_next[`SER_FO_PIN] = 1'b1;
    end
  end

  pin_cell #(.W(`SER_W)) serial_pins (
    .clk_i(clk_i),
    .rst_n_i(rst_n_reg),
    .drive_i(ser_drive_next),
    .oe_i(ser_oe_next),
    .pin_in_i(serial_pin_in_i),
    .pin_out_o(serial_pin_out_o),
    .pin_oe_o(serial_pin_oe_o),
    .sample_o(ser_sample)
  );

  assign irq_level = {ser_sample[`SER_IRQ1_PIN], ser_sample[`SER_IRQ0_PIN]};

  // active-low requests: level mode follows the pin, edge mode pulses on a fall
  always @* begin
    irq_next = `ZERO_IRQ;
    if (serial_alt_en_i) begin
      irq_next = (irq_edge_mode_i & irq_prev_reg & ~irq_level) |
                 (~irq_edge_mode_i & ~irq_level); // [R9]
    end
  end

  // serial status and interrupt outputs; prev starts high while the pin sample starts low, so an edge-mode request can fire on the first cycle after reset
  always @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq_prev_reg <= {`IRQ_W{1'b1}};
      serial_alt_interrupts_o <= `ZERO_IRQ;
      flag_input_o <= 1'b0;
      serial_level_o <= {`SER_W{1'b0}};
    end else begin
      irq_prev_reg <= irq_level;
      serial_alt_interrupts_o <= irq_next;
      flag_input_o <= serial_alt_en_i & ser_sample[`SER_FI_PIN]; // [R9]
      serial_level_o <= ser_sample;
    end
  end

endmodule

/* rtl/strap_mux_defs.vh */
// constants for the memory-mode strap and pin multiplexer
`ifndef STRAP_MUX_DEFS_VH
`define STRAP_MUX_DEFS_VH

// strap value read on the mode-c pin
`define MODE_FULL 1'b0
`define MODE_HOST 1'b1

// strap vector bit positions (mode a, mode b, mode c)
`define STRAP_A_BIT 0
`define STRAP_B_BIT 1
`define STRAP_C_BIT 2

// pin group widths
`define ADDR_W 14
`define DATA_W 24
`define HOST_W 16
`define BYTE_ADDR_W 8
`define FLAG_W 3
`define SER_W 5
`define IRQ_W 2

// data bus split points
`define DATA_LOW_MSB 7
`define DATA_HIGH_LSB 8
`define HOST_DATA_MSB 15

// serial pin positions in the alternate function set
`define SER_IRQ0_PIN 0
`define SER_IRQ1_PIN 1
`define SER_FI_PIN 2
`define SER_FO_PIN 3

// reset values of driven pins
`define ZERO_ADDR 14'h0000
`define ZERO_BYTE 8'h00
`define ZERO_IRQ 2'h0
`define SEL_IDLE 1'b1

`endif

/* rtl/pin_cell.v */
// registered pad cell group: output, enable and input sample
`timescale 1ns/10ps
module pin_cell #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [W-1:0] drive_i,
  input wire [W-1:0] oe_i,
  input wire [W-1:0] pin_in_i,
  output reg [W-1:0] pin_out_o,
  output reg [W-1:0] pin_oe_o,
  output reg [W-1:0] sample_o
);

  // drive and enable leave from flops; enable is low in reset so a strap driver wins
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_o <= {W{1'b0}};
      pin_oe_o <= {W{1'b0}};
      sample_o <= {W{1'b0}};
    end else begin
      pin_out_o <= drive_i;
      pin_oe_o <= oe_i;
      sample_o <= pin_in_i;
    end
  end

endmodule

/* sim/strap_pin_partner.sv */
// strap drivers and pull resistors on the three mode/flag pins
`timescale 1ns/10ps
module strap_pin_partner (
  input wire logic rst_b_i,
  input wire logic [2:0] strap_i,
  input wire logic [2:0] pin_out_i,
  input wire logic [2:0] pin_oe_i,
  output wire logic [2:0] pin_level_o
);
  // driver forces the strap in reset, then floats; the pull keeps that level
  // unless the flag logic drives, so a late strap read is not masked here
  assign pin_level_o = rst_b_i ?
    ((pin_oe_i & pin_out_i) | (~pin_oe_i & strap_i)) : strap_i;
endmodule

/* sim/memory_mode_strap_pin_mux_assertions.sv */
// concurrent checks on the strap capture and pin multiplexer ports
`timescale 1ns/10ps
module memory_mode_strap_pin_mux_assertions (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic host_mode_o,
  input wire logic [2:0] strap_value_o,
  input wire logic [13:0] core_addr_i,
  input wire logic [13:0] ext_addr_out_o,
  input wire logic core_byte_phase_i,
  input wire logic [7:0] core_byte_addr_i,
  input wire logic [23:0] ext_data_bus_out_o,
  input wire logic [23:0] ext_data_bus_oe_o,
  input wire logic hport_ack_i,
  input wire logic host_acknowledge_b_o,
  input wire logic hport_select_o,
  input wire logic serial_alt_en_i,
  input wire logic [1:0] irq_edge_mode_i,
  input wire logic [4:0] serial_pin_in_i,
  input wire logic [1:0] serial_alt_interrupts_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // run phase: internal reset released and pipelines refilled
  sequence settled;
    rst_b_i [*6];
  endsequence
  sequence full_run;
    settled ##0 !host_mode_o;
  endsequence
  sequence host_run;
    settled ##0 host_mode_o;
  endsequence
  mode_frozen_a: assert property (
    settled |=> $stable(host_mode_o) && $stable(strap_value_o))
    else $error("mode changed while running");
  mode_bit_a: assert property (settled |-> host_mode_o == strap_value_o[2])
    else $error("mode does not follow strap");
  full_addr_a: assert property (full_run |-> ext_addr_out_o == $past(core_addr_i))
    else $error("full address wrong");
  host_addr_a: assert property (
    host_run |-> ext_addr_out_o == {13'h0, $past(core_addr_i[0])})
    else $error("host address wrong");
  low_data_off_a: assert property (host_run |-> ext_data_bus_oe_o[7:0] == 8'h00)
    else $error("low data driven in host mode");
  byte_addr_a: assert property (full_run ##0 $past(core_byte_phase_i) |->
    ext_data_bus_out_o[23:16] == $past(core_byte_addr_i) && ext_data_bus_oe_o[23:16] == 8'hFF)
    else $error("byte address missing");
  full_ack_a: assert property (full_run |-> host_acknowledge_b_o && !hport_select_o)
    else $error("host port live in full mode");
  host_ack_a: assert property (host_run |-> host_acknowledge_b_o == !$past(hport_ack_i))
    else $error("acknowledge wrong");
  // enable and edge mode act one cycle before the output, the pin two cycles before
  irq_level_a: assert property (settled ##0 $past(serial_alt_en_i) &&
    !$past(irq_edge_mode_i[1]) |-> serial_alt_interrupts_o[1] == !$past(serial_pin_in_i[1], 2))
    else $error("level interrupt wrong");
endmodule
bind memory_mode_strap_pin_mux memory_mode_strap_pin_mux_assertions u_chk (.*);

/* sim/memory_mode_strap_pin_mux_tb.sv */
// bench for the strap capture and pin multiplexer
`timescale 1ns/10ps
module memory_mode_strap_pin_mux_tb;
  logic clk_i = 0;
  logic rst_b_i = 0;
  logic [2:0] strap = 3'b000;
  logic core_data_oe_i, core_byte_phase_i, core_cms_b_i, core_pms_b_i, core_dms_b_i;
  logic core_io_space_select_b_i, core_bms_b_i, host_write_strobe_b_i, host_read_strobe_b_i;
  logic host_addr_latch_i, host_select_b_i, hport_drive_i, hport_ack_i;
  logic serial_alt_en_i, flag_output_i;
  logic [2:0] flag_drive_i, flag_dir_out_i;
  logic [13:0] core_addr_i;
  logic [23:0] core_wdata_i, ext_data_bus_in_i;
  logic [7:0] core_byte_addr_i;
  logic [15:0] host_addr_data_bus_in_i, hport_rdata_i;
  logic [4:0] serial_pin_in_i, serial_drive_i, serial_oe_i;
  logic [1:0] irq_edge_mode_i;
  wire prog_flag_zero_i, prog_flag_one_i, prog_flag_two_i;
  wire [2:0] prog_flag_out_o, prog_flag_oe_o, flag_level_o, strap_value_o;
  wire host_mode_o, combined_mem_select_b_o, program_mem_select_b_o, data_mem_select_b_o;
  wire io_space_select_b_o, byte_mem_select_b_o, host_acknowledge_b_o, flag_input_o;
  wire hport_write_o, hport_read_o, hport_latch_o, hport_select_o;
  wire [13:0] ext_addr_out_o;
  wire [23:0] core_rdata_o, ext_data_bus_out_o, ext_data_bus_oe_o;
  wire [15:0] host_addr_data_bus_out_o, host_addr_data_bus_oe_o, hport_bus_o;
  wire [4:0] serial_pin_out_o, serial_pin_oe_o, serial_level_o;
  wire [1:0] serial_alt_interrupts_o;
  int error_cnt = 0;
  int cmp_count = 0;
  memory_mode_strap_pin_mux u_dut (.*);
  strap_pin_partner u_strap (.rst_b_i(rst_b_i), .strap_i(strap), .pin_out_i(prog_flag_out_o),
    .pin_oe_i(prog_flag_oe_o), .pin_level_o({prog_flag_two_i, prog_flag_one_i, prog_flag_zero_i}));
  // free running 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  // inputs move 2 ns after the edge, clear of sampling
  task step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // reset held 4 cycles, then room for the release pipeline
  task do_reset(input logic [2:0] s);
    rst_b_i = 0;
    strap = s;
    step(4);
    check("rst_oe", prog_flag_oe_o, 3'b000);
    check("rst_mode", host_mode_o, 1'b0);
    rst_b_i = 1;
    step(6);
  endtask
  task summarize;
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, far beyond the 31 cycles the tests need
  initial begin
    #20000;
    error_cnt++;
    summarize;
  end
  initial begin
    {core_data_oe_i, core_byte_phase_i, host_addr_latch_i, hport_drive_i, hport_ack_i} = '0;
    {serial_alt_en_i, flag_output_i, flag_drive_i, flag_dir_out_i, core_addr_i} = '0;
    {core_wdata_i, ext_data_bus_in_i, core_byte_addr_i, host_addr_data_bus_in_i} = '0;
    {hport_rdata_i, serial_drive_i, serial_oe_i, irq_edge_mode_i} = '0;
    {core_cms_b_i, core_pms_b_i, core_dms_b_i, core_io_space_select_b_i, core_bms_b_i} = '1;
    {host_write_strobe_b_i, host_read_strobe_b_i, host_select_b_i} = '1;
    serial_pin_in_i = 5'h1F;
    // full memory mode, host port must stay dead although its write strobe, select and latch are active
    do_reset(3'b010);
    check("mode", host_mode_o, 1'b0);
    check("strap", strap_value_o, 3'b010);
    core_addr_i = 14'h2A5C;
    core_wdata_i = 24'h9E1D47;
    core_data_oe_i = 1;
    hport_ack_i = 1;
    ext_data_bus_in_i = 24'h5A3C96;
    core_pms_b_i = 0;
    host_addr_data_bus_in_i = 16'h1234;
    {host_write_strobe_b_i, host_select_b_i, host_addr_latch_i, hport_drive_i} = 4'h3;
    step(1);
    check("addr", ext_addr_out_o, 14'h2A5C);
    check("dout", ext_data_bus_out_o, 24'h9E1D47);
    check("doe", ext_data_bus_oe_o, 24'hFFFFFF);
    check("ack", host_acknowledge_b_o, 1'b1);
    check("f_wr", hport_write_o, 1'b0);
    check("f_sel", hport_select_o, 1'b0);
    check("f_lat", hport_latch_o, 1'b0);
    check("f_hoe", host_addr_data_bus_oe_o, 16'h0000);
    check("pms", program_mem_select_b_o, 1'b0);
    check("cms", combined_mem_select_b_o, 1'b1);
    core_byte_phase_i = 1;
    core_byte_addr_i = 8'hC3;
    step(1);
    check("rdata", core_rdata_o, 24'h5A3C96);
    check("baddr", ext_data_bus_out_o[23:16], 8'hC3);
    check("f_hbus", hport_bus_o, 16'h0000);
    // mode pins turn into flags; the strap must not be re-read
    flag_dir_out_i = 3'b101;
    flag_drive_i = 3'b001;
    step(2);
    check("fout", prog_flag_out_o, 3'b001);
    check("foe", prog_flag_oe_o, 3'b101);
    check("flags", flag_level_o, 3'b011);
    check("frozen", strap_value_o, 3'b010);
    // host mode with write strobe, select and latch active at once
    do_reset(3'b100);
    check("mode", host_mode_o, 1'b1);
    core_addr_i = 14'h3FFF;
    core_wdata_i = 24'h00BEEF;
    core_io_space_select_b_i = 0;
    host_write_strobe_b_i = 0;
    host_addr_data_bus_in_i = 16'h4321;
    hport_drive_i = 1;
    hport_rdata_i = 16'hA55A;
    step(1);
    check("addr", ext_addr_out_o, 14'h0001);
    check("dout", ext_data_bus_out_o[23:8], 16'hBEEF);
    check("doe", ext_data_bus_oe_o[7:0], 8'h00);
    check("doeh", ext_data_bus_oe_o[23:8], 16'hFFFF);
    check("ack", host_acknowledge_b_o, 1'b0);
    check("wr", hport_write_o, 1'b1);
    check("sel", hport_select_o, 1'b1);
    check("lat", hport_latch_o, 1'b1);
    check("hout", host_addr_data_bus_out_o, 16'hA55A);
    check("hoe", host_addr_data_bus_oe_o, 16'hFFFF);
    check("io_space_select", io_space_select_b_o, 1'b0);
    step(1);
    check("rdata", core_rdata_o, 24'h005A3C);
    check("hbus", hport_bus_o, 16'h4321);
    // alternate serial functions: edge irq0, level irq1, flags; acknowledge withdrawn
    serial_alt_en_i = 1;
    irq_edge_mode_i = 2'b01;
    flag_output_i = 1;
    hport_ack_i = 0;
    step(2);
    check("fo", serial_pin_out_o[3], 1'b1);
    check("fo_oe", serial_pin_oe_o[3], 1'b1);
    check("fi_hi", flag_input_o, 1'b1);
    check("ack_off", host_acknowledge_b_o, 1'b1);
    serial_pin_in_i = 5'h18;
    step(2);
    check("irq", serial_alt_interrupts_o, 2'b11);
    check("fi", flag_input_o, 1'b0);
    check("slev", serial_level_o, 5'h18);
    step(1);
    check("irq", serial_alt_interrupts_o, 2'b10);
    summarize;
  end
endmodule
